/* drc_map.svh */
// constants of the drive auto-restart supervisor: offsets, fields, resets, timing
// assumes a 40 MHz system clock and byte offsets on the plain register port
//
// Behaviour
// R1: manual: run at power-up waits for retoggle
// R2: run means enable with forward or reverse
// R3: manual fault: reset plus run retoggle needed
// R4: manual, zero limit: only manual reset clears
// R5: manual, nonzero limit: auto reset, still retoggle
// R6: policy 1: power-up start, no fault restart
// R7: policy 2: delayed fault restart, no power-up start
// R8: policy 3: restart at power-up and after faults
// R9: three-wire mode never restarts on its own
// R10: attempts capped at limit 0..10, default 3
// R11: attempt count cleared hourly and at power-up; the code clears it hourly only while it is below the limit
// R12: restart delay 0..3600 s, default 3
// R13: wait delay before reset; retry gets new delay
// R14: one-second tick times delay and hour window
`ifndef DRC_MAP_SVH
`define DRC_MAP_SVH

// register byte offsets
`define DRC_OFF_CTRL    8'h00
`define DRC_OFF_LIMIT   8'h04
`define DRC_OFF_DELAY   8'h08
`define DRC_OFF_STATUS  8'h0C
`define DRC_OFF_MASK    8'h10
`define DRC_OFF_STATE   8'h14

// control fields
`define DRC_CTRL_POL_LSB   0
`define DRC_CTRL_3W_BIT    2

// reset values and maxima
`define DRC_POLICY_RST     2'h1
`define DRC_LIMIT_RST      4'h3
`define DRC_LIMIT_MAX      4'hA
`define DRC_DELAY_RST      12'h003
`define DRC_DELAY_MAX      12'hE10

// policy codes
`define DRC_POL_MANUAL     2'h0
`define DRC_POL_PWRUP      2'h1
`define DRC_POL_FAULT      2'h2
`define DRC_POL_BOTH       2'h3

// status event bits
`define DRC_EV_FAULT       0
`define DRC_EV_AUTORST     1
`define DRC_EV_LOCKOUT     2
`define DRC_EV_START       3

// timing: the tick period in seconds, the clock rate, the hour in seconds
`define DRC_CLK_HZ         40000000
`define DRC_TICK_PERIOD_S  1
`define DRC_TICK_CYCLES    (`DRC_CLK_HZ * `DRC_TICK_PERIOD_S)
`define DRC_HOUR_S         3600

`endif

/* drc_pkg.sv */
// types of the drive auto-restart supervisor
// assumes drc_map.svh for every number
package drc_pkg;

  // one-hot supervisor states
  typedef enum logic [6:0] {
    ST_PWRUP = 7'h01,  // first cycle after power-up
    ST_IDLE  = 7'h02,  // stopped, run absent
    ST_HOLD  = 7'h04,  // stopped until run is removed
    ST_RUN   = 7'h08,  // motor permitted
    ST_FAULT = 7'h10,  // fault present, waiting
    ST_DELAY = 7'h20,  // restart delay counting
    ST_CHECK = 7'h40   // auto reset issued, watching fault
  } drc_state_t;

  // whole state of the main module
  typedef struct packed {
    drc_state_t  st;
    logic [1:0]  policy;
    logic        three_wire;
    logic [3:0]  limit;
    logic [11:0] delay_set;
    logic [11:0] remain;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic [31:0] rdata;
    logic        run_permit;
    logic        auto_reset;
    logic        lockout;
    logic        irq;
  } drc_main_t;

endpackage : drc_pkg

/* drc_cnt_if.sv */
// signals shared by the supervisor, its tick source and its attempt counter
// assumes one clock for all three modules
`timescale 1ns/1ps
interface drc_cnt_if;
  logic       tick;      // one-cycle pulse each second
  logic       inc;       // one attempt made
  logic [3:0] limit;     // attempts allowed per hour
  logic [3:0] count;     // attempts made this hour
  logic       at_limit;  // count has reached limit

  modport tick_src (output tick);
  modport main     (input tick, count, at_limit, output inc, limit);
  modport cnt      (input tick, inc, limit, output count, at_limit);
endinterface : drc_cnt_if

/* drc_tick.sv */
// one-second tick prescaler for the restart supervisor
// assumes a free-running system clock at the rate of the map header
`timescale 1ns/1ps
module drc_tick
  import drc_pkg::*;
#(
  parameter int TICK_CYCLES = 40000000  // clock cycles per second
)(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  drc_cnt_if.tick_src t
);
  localparam int W = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;   // cycles into this second
    logic         tick;  // pulse
  } drc_tick_t;

  drc_tick_t s;
  drc_tick_t next_s;

  ////////////////////////////////////////////////////////////////
  // prescaler
  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == W'(TICK_CYCLES - 1))
    begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;  // [R14]
    end
    else
    begin
      next_s.cnt = s.cnt + W'(1);
    end
  end

  // register, cleared by reset
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      s <= '0;  // [R14]
    else
      s <= next_s;
  end

  assign t.tick = s.tick;

  ////////////////////////////////////////////////////////////////
  // ticks are isolated single-cycle pulses
  tick_single_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    s.tick |=> !s.tick) else $error("tick longer than one cycle");  // [R14]

endmodule : drc_tick

/* drc_attempts.sv */
// restart attempt counter with its one-hour window
// assumes the seconds tick and attempt pulses arrive over the shared interface
`timescale 1ns/1ps
module drc_attempts
  import drc_pkg::*;
#(
  parameter int HOUR_S = 3600  // window length in seconds
)(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  drc_cnt_if.cnt c
);
  typedef struct packed {
    logic [11:0] secs;   // seconds into the window
    logic [3:0]  count;  // attempts in the window
  } drc_att_t;

  drc_att_t s;
  drc_att_t next_s;
  logic     win_end;    // last second of the window

  ////////////////////////////////////////////////////////////////
  // window and count
  always_comb
  begin
    next_s  = s;
    win_end = c.tick && (s.secs == 12'(HOUR_S - 1));
    if (c.tick)
      next_s.secs = win_end ? 12'h000 : s.secs + 12'h001;
    // a quiet hour forgets earlier attempts; a locked hour keeps them
    if (win_end && (s.count < c.limit))
      next_s.count = 4'h0;  // [R11]
    else if (c.inc && (s.count != 4'hF))
      next_s.count = s.count + 4'h1;  // [R10]
  end

  // power cycle clears the count
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      s <= '0;  // [R11] [R14]
    else
      s <= next_s;
  end

  assign c.count    = s.count;
  assign c.at_limit = (s.count >= c.limit);  // [R10]

  ////////////////////////////////////////////////////////////////
  hour_clear_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    win_end && !c.inc && (s.count < c.limit) |=> s.count == 4'h0)  // [R11]
    else $error("count not cleared after a quiet hour");

endmodule : drc_attempts

/* drc_supervisor.sv */
// auto-restart supervisor of a motor drive: decides when the motor may run
// assumes synchronous operator inputs, a fault level from the drive fault logic
// and a single-cycle register port with read data one cycle later
// and fault logic that answers an auto reset one cycle later
//
// Added by the designer: strobed register access and the register offsets.
`include "drc_map.svh"
`timescale 1ns/1ps
module drc_supervisor
  import drc_pkg::*;
#(
  parameter int TICK_CYCLES = `DRC_TICK_CYCLES,  // cycles per second tick
  parameter int HOUR_S      = `DRC_HOUR_S         // attempt window in seconds
)(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        enable_i,        // operator enable
  input  wire logic        forward_cmd_i,   // forward direction
  input  wire logic        reverse_cmd_i,   // reverse direction
  input  wire logic        fault_i,         // drive fault present
  input  wire logic        manual_reset_i,  // operator fault reset pulse
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             run_permit_o,    // motor may run
  output logic             auto_reset_o,    // fault reset request pulse
  output logic             lockout_o,       // manual restart needed
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////
  // helpers and submodules
  // tick and attempt counter share one bundle
  drc_cnt_if cif ();

  drc_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .t      (cif.tick_src)
  );

  drc_attempts #(
    .HOUR_S (HOUR_S)
  ) u_att (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .c      (cif.cnt)
  );

  // clamp a written value to its top of range
  function automatic logic [11:0] clamp12(input logic [11:0] v, input logic [11:0] top);
    clamp12 = (v > top) ? top : v;
  endfunction : clamp12

  drc_main_t  s;            // registered state
  drc_main_t  next_s;       // next state
  logic       run_now;      // run command present
  logic       auto_pwr;     // policy allows start at power-up
  logic       auto_flt;     // policy allows restart after fault
  logic       may_try;      // an automatic reset may be attempted
  logic [3:0] ev;           // events this cycle
  logic [3:0] w1c;          // status bits written with one

  // run needs enable and a direction
  assign run_now  = enable_i && (forward_cmd_i || reverse_cmd_i);  // [R2]
  assign auto_pwr = (s.policy == `DRC_POL_PWRUP) || (s.policy == `DRC_POL_BOTH);  // [R6] [R8]
  assign auto_flt = (s.policy == `DRC_POL_FAULT) || (s.policy == `DRC_POL_BOTH);  // [R7] [R8]
  // policy 1 never retries; otherwise need a nonzero limit not yet used up
  assign may_try  = (s.policy != `DRC_POL_PWRUP) && (s.limit != 4'h0) && !cif.at_limit;  // [R4] [R10]
  // counter compares against the live limit
  assign cif.limit = s.limit;

  ////////////////////////////////////////////////////////////////
  // next-state logic: supervisor, registers, events
  always_comb
  begin
    next_s     = s;
    ev         = 4'h0;
    w1c        = 4'h0;
    cif.inc    = 1'b0;
    next_s.auto_reset = 1'b0;
    next_s.rdata      = 32'h0000_0000;

    // register writes
    if (wr_i)
    begin
      unique case (addr_i)
        `DRC_OFF_CTRL:
        begin
          // policy and three-wire share a word
          next_s.policy     = wdata_i[`DRC_CTRL_POL_LSB +: 2];
          next_s.three_wire = wdata_i[`DRC_CTRL_3W_BIT];
        end
        // limit field values 11..15 saturate at 10; data bits above bit 3 are dropped
        `DRC_OFF_LIMIT:  next_s.limit = 4'(clamp12({8'h00, wdata_i[3:0]}, {8'h00, `DRC_LIMIT_MAX}));  // [R10]
        `DRC_OFF_DELAY:  next_s.delay_set = clamp12(wdata_i[11:0], `DRC_DELAY_MAX);  // [R12]
        // ones written clear status bits
        `DRC_OFF_STATUS: w1c = wdata_i[3:0];
        `DRC_OFF_MASK:   next_s.mask = wdata_i[3:0];
        default:         ;  // unmapped writes ignored
      endcase
    end

    // register reads, data stand one cycle
    if (rd_i)
    begin
      unique case (addr_i)
        `DRC_OFF_CTRL:   next_s.rdata = {29'h0, s.three_wire, s.policy};
        `DRC_OFF_LIMIT:  next_s.rdata = {28'h0, s.limit};
        `DRC_OFF_DELAY:  next_s.rdata = {20'h0, s.delay_set};
        `DRC_OFF_STATUS: next_s.rdata = {28'h0, s.status};
        `DRC_OFF_MASK:   next_s.rdata = {28'h0, s.mask};
        // remain, count, lockout, state
        `DRC_OFF_STATE:  next_s.rdata = {8'h00, s.remain, cif.count, s.lockout, s.st};
        default:         next_s.rdata = 32'h0000_0000;  // unmapped reads zero
      endcase
    end

    // restart delay counts whole seconds
    if (cif.tick && (s.remain != 12'h000))
      next_s.remain = s.remain - 12'h001;  // [R14]

    // supervisor
    unique case (s.st)
      ST_PWRUP:
      begin
        // run already present at power-up: start only if policy allows
        if (fault_i)
          next_s.st = ST_FAULT;
        // three-wire always wants a fresh press
        else if (run_now && auto_pwr && !s.three_wire)
          next_s.st = ST_RUN;  // [R6] [R8]
        else if (run_now)
          next_s.st = ST_HOLD;  // [R1] [R7] [R9]
        else
          next_s.st = ST_IDLE;
      end

      // idle: fresh run starts at once
      ST_IDLE:
      begin
        if (fault_i)
          next_s.st = ST_FAULT;
        else if (run_now)
          next_s.st = ST_RUN;
      end

      // hold: stale run is ignored
      ST_HOLD:
      begin
        // wait for the run command to be removed
        if (fault_i)
          next_s.st = ST_FAULT;
        else if (!run_now)
          next_s.st = ST_IDLE;  // [R1] [R3]
      end

      // run: left on fault or stop
      ST_RUN:
      begin
        if (fault_i)
          next_s.st = ST_FAULT;
        else if (!run_now)
          next_s.st = ST_IDLE;
      end

      // fault: reset, clear, retry or lock
      ST_FAULT:
      begin
        // manual reset always wins; the run command must then be retoggled
        if (manual_reset_i)
        begin
          next_s.st      = run_now ? ST_HOLD : ST_IDLE;  // [R3]
          next_s.lockout = 1'b0;
        end
        // fault went away on its own
        else if (!fault_i && !s.lockout)
          next_s.st = run_now ? ST_HOLD : ST_IDLE;
        // retry allowed: fresh delay
        else if (may_try)
        begin
          next_s.st     = ST_DELAY;
          next_s.remain = s.delay_set;  // [R13]
        end
        // no retry left: latch once
        else if (!s.lockout)
        begin
          next_s.lockout = 1'b1;  // [R4] [R10]
          ev[`DRC_EV_LOCKOUT] = 1'b1;
        end
      end

      // delay: seconds count to zero
      ST_DELAY:
      begin
        // fire the reset once the delay has fully run out
        if (manual_reset_i)
          next_s.st = run_now ? ST_HOLD : ST_IDLE;  // [R3]
        // one attempt counted per pulse
        else if (s.remain == 12'h000)
        begin
          next_s.st         = ST_CHECK;
          next_s.auto_reset = 1'b1;  // [R5] [R7] [R13]
          cif.inc           = 1'b1;  // [R10]
          ev[`DRC_EV_AUTORST] = 1'b1;
        end
      end

      // check: did the reset take
      ST_CHECK:
      begin
        // give the fault logic until the next second tick to clear;
        // a tick in the pulse cycle is skipped, since the fault
        // logic cannot have answered yet and the try would be lost
        if (manual_reset_i)
          next_s.st = run_now ? ST_HOLD : ST_IDLE;  // [R3]
        else if (cif.tick && !s.auto_reset && !fault_i)
        begin
          if (run_now && auto_flt && !s.three_wire)
            next_s.st = ST_RUN;  // [R7] [R8]
          else
            next_s.st = run_now ? ST_HOLD : ST_IDLE;  // [R5] [R9]
        end
        else if (cif.tick && !s.auto_reset)
          next_s.st = ST_FAULT;  // retry restarts the delay [R13]
      end

      // other codes: corrupt register
      default:
      begin
        next_s.st = ST_PWRUP;  // illegal code recovers via power-up path
      end
    endcase

    // a failed retry is no new fault
    if ((next_s.st == ST_FAULT) && (s.st != ST_FAULT) && (s.st != ST_CHECK))
      ev[`DRC_EV_FAULT] = 1'b1;
    // start event on each entry to run
    if ((next_s.st == ST_RUN) && (s.st != ST_RUN))
      ev[`DRC_EV_START] = 1'b1;

    // motor permission follows the state entered
    next_s.run_permit = (next_s.st == ST_RUN);  // [R2]

    // sticky events: a new event beats a same-cycle clear
    next_s.status = (s.status & ~w1c) | ev;
    next_s.irq    = |(next_s.status & next_s.mask);
  end

  ////////////////////////////////////////////////////////////////
  // state register; reset is a power cycle
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      // settings return to defaults too
      s            <= '0;
      s.st         <= ST_PWRUP;
      s.policy     <= `DRC_POLICY_RST;  // [R6]
      s.limit      <= `DRC_LIMIT_RST;   // [R10]
      s.delay_set  <= `DRC_DELAY_RST;   // [R12]
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs are state register fields
  assign rdata_o      = s.rdata;
  assign run_permit_o = s.run_permit;
  assign auto_reset_o = s.auto_reset;
  assign lockout_o    = s.lockout;
  assign irq_o        = s.irq;

  ////////////////////////////////////////////////////////////////
  // checks
  // all checks on the system clock
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // permission follows a run command
  run_needs_cmd_a : assert property (run_permit_o |-> $past(run_now))  // [R2]
    else $error("motor permitted without a run command");

  // manual never starts at power-up
  pwr_manual_hold_a : assert property (  // [R1]
    (s.st == ST_PWRUP) && !fault_i && run_now && (s.policy == `DRC_POL_MANUAL)
    |=> (s.st == ST_HOLD) && !run_permit_o)
    else $error("manual policy started at power-up");

  // policies 1 and 3 start at power-up
  pwr_auto_start_a : assert property (  // [R6]
    (s.st == ST_PWRUP) && !fault_i && run_now && s.policy[0] && !s.three_wire
    |=> run_permit_o)
    else $error("power-up start missing");

  // policy 2 holds at power-up
  pwr_after_fault_a : assert property (  // [R7]
    (s.st == ST_PWRUP) && (s.policy == `DRC_POL_FAULT) |=> !run_permit_o)
    else $error("after-fault policy started at power-up");

  // zero limit: no delay, no reset
  manual_only_a : assert property (  // [R4]
    (s.st == ST_FAULT) && (s.limit == 4'h0) |=> (s.st != ST_DELAY))
    else $error("zero limit allowed an automatic reset");

  // policy 1 never retries
  pwrup_no_retry_a : assert property (  // [R6]
    (s.policy == `DRC_POL_PWRUP) && (s.st == ST_FAULT) |=> !auto_reset_o && (s.st != ST_DELAY))
    else $error("power-up policy retried after fault");

  // manual never resumes from check
  manual_retoggle_a : assert property (  // [R3]
    (s.st == ST_CHECK) && (s.policy == `DRC_POL_MANUAL) |=> !run_permit_o)
    else $error("manual policy resumed without retoggle");

  // three-wire contacts are open
  three_wire_a : assert property (  // [R9]
    s.three_wire && ((s.st == ST_CHECK) || (s.st == ST_PWRUP)) |=> !run_permit_o)
    else $error("three-wire mode restarted on its own");

  // resets only below the cap
  attempt_cap_a : assert property (  // [R10]
    auto_reset_o |-> !$past(cif.at_limit) && ($past(s.st) == ST_DELAY))
    else $error("automatic reset beyond the attempt limit");

  // reset only after the delay
  delay_done_a : assert property (  // [R13]
    auto_reset_o |-> ($past(s.remain) == 12'h000) ##1 (s.st == ST_CHECK))
    else $error("automatic reset before the delay ran out");

  // settings stay in range
  limit_range_a : assert property ((s.limit <= `DRC_LIMIT_MAX) && (s.delay_set <= `DRC_DELAY_MAX))  // [R12]
    else $error("setting out of range");

  // main scenarios
  auto_restart_c : cover property ((s.st == ST_CHECK) ##1 (s.st == ST_RUN));
  lockout_c      : cover property ($rose(lockout_o));
  retry_c        : cover property ((s.st == ST_CHECK) ##1 (s.st == ST_FAULT));
  pwrup_start_c  : cover property ((s.st == ST_PWRUP) ##1 run_permit_o);

endmodule : drc_supervisor

/* drc_plant.sv */
// behavioural model of the drive fault logic facing the restart supervisor
// assumes the supervisor's clock and reset and its auto reset pulse output
`timescale 1ns/1ps
module drc_plant
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic trip_i,          // bench-commanded fault event
  input  wire logic persist_i,       // fault survives an auto reset
  input  wire logic auto_reset_i,    // reset request from the supervisor
  input  wire logic manual_reset_i,  // operator reset, clears unless trip_i is high
  output logic      fault_o          // fault level to the supervisor
);
  ////////////////////////////////////////////////////////////////////////
  // fault latch: a persistent fault ignores auto resets, so retries fail
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      fault_o <= 1'b0;
    else if (trip_i)
      fault_o <= 1'b1;
    else if ((auto_reset_i && !persist_i) || manual_reset_i)
      fault_o <= 1'b0;
  end
endmodule : drc_plant

/* drive_auto_restart_control_tb_top.sv */
// self-checking bench of the drive auto-restart supervisor
// assumes the map header, package, interface, design files and plant model
`include "drc_map.svh"
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin fail_count++; $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
`define WAITFOR(c, n) for (int k = 0; k < (n) && !(c); k++) @(posedge clk_i);
module drive_auto_restart_control_tb_top
  import drc_pkg::*;
;
  localparam int TCK  = 4;   // short second keeps runs brief
  localparam int HOUR = 50;  // window of 200 cycles
  logic        clk_i, rstn_i, enable_i, forward_cmd_i, reverse_cmd_i;
  logic        fault_i, manual_reset_i, wr_i, rd_i, trip, persist;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic        run_permit_o, auto_reset_o, lockout_o, irq_o;
  logic        rd_d = 1'b0;  // read taken last edge
  logic [63:0] note_q[$];    // expected reads: {mask, value}
  logic [63:0] nt;
  logic [2:0]  v;
  int          fail_count, checked, ar_cnt, cyc, base, t0, seed_v;

  ////////////////////////////////////////////////////////////////////////
  // clock and instances
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  drc_supervisor #(.TICK_CYCLES(TCK), .HOUR_S(HOUR)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .enable_i(enable_i), .forward_cmd_i(forward_cmd_i),
    .reverse_cmd_i(reverse_cmd_i), .fault_i(fault_i), .manual_reset_i(manual_reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .run_permit_o(run_permit_o), .auto_reset_o(auto_reset_o), .lockout_o(lockout_o), .irq_o(irq_o));
  drc_plant u_plant (
    .clk_i(clk_i), .rstn_i(rstn_i), .trip_i(trip), .persist_i(persist),
    .auto_reset_i(auto_reset_o), .manual_reset_i(manual_reset_i), .fault_o(fault_i));

  ////////////////////////////////////////////////////////////////////////
  // monitor: read data stands only in the cycle after the strobe
  always @(posedge clk_i)
  begin
    cyc++;
    if (auto_reset_o === 1'b1)
      ar_cnt++;
    if (rd_d === 1'b1)
    begin
      nt = note_q.pop_front();
      `CHK("rdata", nt[31:0], rdata_o & nt[63:32])
    end
    rd_d <= rd_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // bus and operator tasks, all changes just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
    note_q.push_back({mk, ex});
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : rd
  // one-cycle pulse: manual reset when sel is high, else a fault trip
  task automatic pulse(input logic sel);
    @(posedge clk_i);
    manual_reset_i <= sel;
    trip           <= !sel;
    @(posedge clk_i);
    manual_reset_i <= 1'b0;
    trip           <= 1'b0;
  endtask : pulse
  task automatic set_run(input logic [2:0] r);
    @(posedge clk_i);
    {enable_i, forward_cmd_i, reverse_cmd_i} <= r;
    repeat (3) @(posedge clk_i);
  endtask : set_run
  // remove then reapply the run command
  task automatic retoggle;
    set_run(3'b000);
    set_run(3'b110);
  endtask : retoggle
  // power cycle with the run command already set
  task automatic por(input logic [2:0] r);
    @(posedge clk_i);
    rstn_i  <= 1'b0;
    persist <= 1'b0;
    {enable_i, forward_cmd_i, reverse_cmd_i} <= r;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask : por
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs about a thousand cycles at most
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rstn_i, enable_i, forward_cmd_i, reverse_cmd_i, manual_reset_i} = '0;
    {wr_i, rd_i, trip, persist} = '0;
    addr_i  = 8'h00;
    wdata_i = 32'h0;
    seed_v  = $urandom(28037);
    por(3'b000);
    // reset values and an unmapped read
    rd(`DRC_OFF_CTRL, 32'h1, 32'h7);
    rd(`DRC_OFF_LIMIT, 32'h3, 32'hF);
    rd(`DRC_OFF_DELAY, 32'h3, 32'hFFF);
    rd(`DRC_OFF_STATUS, 32'h0, 32'hF);
    rd(`DRC_OFF_MASK, 32'h0, 32'hF);
    rd(8'h18, 32'h0, 32'hFFFFFFFF);
    rd(`DRC_OFF_STATE, 32'h02, 32'hFFF);
    // run decode: every input combination, then random ones
    for (int i = 0; i < 14; i++)
    begin
      v = (i < 8) ? 3'(i) : 3'($urandom % 8);
      set_run(v);
      `CHK("run_permit", v[2] & (v[1] | v[0]), run_permit_o)
    end
    set_run(3'b110);
    // power-up policy: fault gives no retry, lockout and interrupt
    wr(`DRC_OFF_MASK, 32'h5);
    pulse(1'b0);
    `WAITFOR(lockout_o === 1'b1, 40)
    `CHK("lockout", 1'b1, lockout_o)
    `CHK("auto resets", 0, ar_cnt)
    `CHK("irq", 1'b1, irq_o)
    rd(`DRC_OFF_STATUS, 32'h5, 32'h5);
    wr(`DRC_OFF_STATUS, 32'hF);
    rd(`DRC_OFF_STATUS, 32'h0, 32'hF);
    repeat (2) @(posedge clk_i);
    `CHK("irq", 1'b0, irq_o)
    pulse(1'b1);
    repeat (3) @(posedge clk_i);
    rd(`DRC_OFF_STATE, 32'h04, 32'hFF);
    `CHK("run_permit", 1'b0, run_permit_o)
    retoggle();
    `CHK("run_permit", 1'b1, run_permit_o)
    // power cycle with run present: starts at once, hour window restarts
    por(3'b110);
    repeat (3) @(posedge clk_i);
    `CHK("run_permit", 1'b1, run_permit_o)
    // after-fault policy, zero delay: reset then resume
    wr(`DRC_OFF_LIMIT, 32'h2);
    wr(`DRC_OFF_DELAY, 32'h0);
    wr(`DRC_OFF_CTRL, 32'h2);
    base = ar_cnt;
    pulse(1'b0);
    `WAITFOR(ar_cnt == base + 1, 60)
    `WAITFOR(run_permit_o === 1'b1, 30)
    `CHK("run_permit", 1'b1, run_permit_o)
    rd(`DRC_OFF_STATE, 32'h108, 32'hFFF);
    // a full window below the limit clears the count
    repeat (HOUR * TCK + 20) @(posedge clk_i);
    rd(`DRC_OFF_STATE, 32'h0, 32'hF00);
    // persistent fault: retries until the cap, then lockout
    persist <= 1'b1;
    base = ar_cnt;
    pulse(1'b0);
    `WAITFOR(lockout_o === 1'b1, 200)
    `CHK("lockout", 1'b1, lockout_o)
    `CHK("auto resets", base + 2, ar_cnt)
    rd(`DRC_OFF_STATE, 32'h290, 32'hFFF);
    persist <= 1'b0;
    pulse(1'b1);
    por(3'b110);
    repeat (3) @(posedge clk_i);
    rd(`DRC_OFF_STATE, 32'h008, 32'hFFF);
    // manual policy, zero limit: only a manual reset clears
    wr(`DRC_OFF_LIMIT, 32'h0);
    wr(`DRC_OFF_CTRL, 32'h0);
    base = ar_cnt;
    pulse(1'b0);
    `WAITFOR(lockout_o === 1'b1, 40)
    repeat (20) @(posedge clk_i);
    `CHK("lockout", 1'b1, lockout_o)
    `CHK("auto resets", base, ar_cnt)
    pulse(1'b1);
    retoggle();
    `CHK("run_permit", 1'b1, run_permit_o)
    // manual policy, nonzero limit: auto reset but no restart
    wr(`DRC_OFF_LIMIT, 32'h1);
    wr(`DRC_OFF_DELAY, 32'h0);
    base = ar_cnt;
    pulse(1'b0);
    `WAITFOR(ar_cnt == base + 1, 60)
    repeat (12) @(posedge clk_i);
    `CHK("run_permit", 1'b0, run_permit_o)
    rd(`DRC_OFF_STATE, 32'h04, 32'h7F);
    retoggle();
    `CHK("run_permit", 1'b1, run_permit_o)
    // three-wire, both policy: reset issued, start withheld
    wr(`DRC_OFF_LIMIT, 32'h3);
    wr(`DRC_OFF_CTRL, 32'h7);
    base = ar_cnt;
    pulse(1'b0);
    `WAITFOR(ar_cnt == base + 1, 60)
    repeat (12) @(posedge clk_i);
    `CHK("run_permit", 1'b0, run_permit_o)
    retoggle();
    `CHK("run_permit", 1'b1, run_permit_o)
    // both policy, two-second delay timed by the tick
    wr(`DRC_OFF_CTRL, 32'h3);
    wr(`DRC_OFF_DELAY, 32'h2);
    base = ar_cnt;
    pulse(1'b0);
    t0 = cyc;
    `WAITFOR(ar_cnt == base + 1, 60)
    `CHK("delay window", 1'b1, (cyc - t0 >= 5) && (cyc - t0 <= 16))
    `WAITFOR(run_permit_o === 1'b1, 30)
    `CHK("run_permit", 1'b1, run_permit_o)
    // settings saturate at their maxima
    wr(`DRC_OFF_LIMIT, 32'hF);
    rd(`DRC_OFF_LIMIT, 32'hA, 32'hF);
    wr(`DRC_OFF_DELAY, 32'hFFF);
    rd(`DRC_OFF_DELAY, 32'hE10, 32'hFFF);
    repeat (3) @(posedge clk_i);
    summarize();
  end
endmodule : drive_auto_restart_control_tb_top
